// [rtl/vimr_cfg.svh]
`ifndef VIMR_CFG_SVH
`define VIMR_CFG_SVH

// ******************************
// Register file addresses
// ******************************
`define VIMR_ADDR_REQ        8'hfa
`define VIMR_ADDR_MASK       8'hfb

// ******************************
// Field positions and resets
// ******************************
`define VIMR_NUM_SRC         6
`define VIMR_GLOBAL_BIT      7
`define VIMR_MASK_RSVD_BIT   6
`define VIMR_REQ_RESET       8'h00
`define VIMR_MASK_RESET      8'h00
`define VIMR_SRC_FIELD       6'h3f
`define VIMR_VEC_BASE        8'h02

`endif

// [rtl/vimr_pkg.sv]
package vimr_pkg;

   typedef enum logic [1:0] {
      VIMR_ST_RUN,
      VIMR_ST_SERVICE
   } vimr_state_t;

   typedef struct packed {
      logic [7:0]  req;
      logic [7:0]  mask;
      vimr_state_t phase;
   } vimr_regs_t;

endpackage

// [rtl/vimr_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module vimr_sync (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta;

   // ******************************
   // Two-stage synchroniser
   // ******************************
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule
`default_nettype wire

// [rtl/vimr_prio.sv]
`timescale 1ns/10ps
`default_nettype none
module vimr_prio
   import vimr_pkg::*;
(
   input  wire logic [5:0] eligible,
   output logic            any,
   output logic [2:0]      index,
   output logic [5:0]      onehot
);

   // ******************************
   // Lowest index wins
   // ******************************
   always_comb begin
      any    = 1'b0;
      index  = 3'h0;
      onehot = 6'h00;
      for (int i = 5; i >= 0; i--) begin
         if (eligible[i]) begin
            any    = 1'b1;
            index  = 3'(i);
            onehot = 6'h01 << i;
         end
      end
   end

endmodule
`default_nettype wire

// [rtl/vimr_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vimr_cfg.svh"
module vimr_ctrl
   import vimr_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic [5:0] src_pulse,
   input  wire logic [5:0] edge_pin,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            reg_hit,
   input  wire logic       global_enable_instruction,
   input  wire logic       global_disable_instruction,
   input  wire logic       return_from_interrupt_instruction,
   input  wire logic       vector_ack,
   output logic            irq_pending,
   output logic [2:0]      irq_index,
   output logic [7:0]      vector_addr,
   output logic            in_service
);

   vimr_regs_t  cur;
   vimr_regs_t  next_cur;
   logic [5:0]  pin_sync;
   logic [5:0]  pin_last;
   logic [5:0]  pin_rise;
   logic [5:0]  hw_set;
   logic [5:0]  eligible;
   logic        win_any;
   logic [2:0]  win_idx;
   logic [5:0]  win_hot;
   logic        wr_req;
   logic        wr_mask;
   logic        take;
   logic [7:0]  rdata_q;

   // ******************************
   // Pin edge sources
   // ******************************
   for (genvar g = 0; g < `VIMR_NUM_SRC; g++) begin : g_sync
      vimr_sync u_sync (
         .ref_clk  (ref_clk),
         .reset    (reset),
         .async_in (edge_pin[g]),
         .sync_out (pin_sync[g])
      );
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_last <= 6'h00;
      end else begin
         pin_last <= pin_sync;
      end
   end

   // Pin edges only fire after sync, so metastability never reaches the flags
   assign pin_rise = pin_sync & ~pin_last;
   assign hw_set   = src_pulse | pin_rise;

   // ******************************
   // Recognition and priority
   // ******************************
   // Global bit gates everything; per-source bits stay stored
   assign eligible = cur.req[5:0] & cur.mask[5:0]
                     & {6{cur.mask[`VIMR_GLOBAL_BIT]}};

   vimr_prio u_prio (
      .eligible (eligible),
      .any      (win_any),
      .index    (win_idx),
      .onehot   (win_hot)
   );

   assign irq_pending = win_any;
   assign irq_index   = win_idx;
   assign vector_addr = `VIMR_VEC_BASE + {4'h0, win_idx, 1'b0};
   assign take        = vector_ack & win_any;
   assign in_service  = (cur.phase == VIMR_ST_SERVICE);

   assign wr_req  = reg_wr & (reg_addr == `VIMR_ADDR_REQ);
   assign wr_mask = reg_wr & (reg_addr == `VIMR_ADDR_MASK);
   assign reg_hit = (reg_wr | reg_rd)
                    & ((reg_addr == `VIMR_ADDR_REQ) | (reg_addr == `VIMR_ADDR_MASK));

   // ******************************
   // State update
   // ******************************
   always_comb begin
      next_cur = cur;
      // Acknowledge clears first so a fresh event in the same cycle is kept
      if (take) begin
         next_cur.req[5:0] = cur.req[5:0] & ~win_hot;
      end
      next_cur.req[5:0] = next_cur.req[5:0] | hw_set;
      // Write-back wins over same-cycle source pulses by design
      if (wr_req) begin
         next_cur.req = reg_wdata;
      end
      if (wr_mask) begin
         next_cur.mask = reg_wdata;
      end
      if (global_enable_instruction) begin
         next_cur.mask[`VIMR_GLOBAL_BIT] = 1'b1;
      end
      if (global_disable_instruction) begin
         next_cur.mask[`VIMR_GLOBAL_BIT] = 1'b0;
      end
      unique case (cur.phase)
         VIMR_ST_RUN: begin
            if (take) begin
               next_cur.mask[`VIMR_GLOBAL_BIT] = 1'b0;
               next_cur.phase = VIMR_ST_SERVICE;
            end
         end
         VIMR_ST_SERVICE: begin
            if (return_from_interrupt_instruction) begin
               next_cur.mask[`VIMR_GLOBAL_BIT] = 1'b1;
               next_cur.phase = VIMR_ST_RUN;
            end else if (take) begin
               next_cur.mask[`VIMR_GLOBAL_BIT] = 1'b0;
            end
         end
         default: begin
            next_cur.phase = VIMR_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cur.req   <= `VIMR_REQ_RESET;
         cur.mask  <= `VIMR_MASK_RESET;
         cur.phase <= VIMR_ST_RUN;
         rdata_q   <= 8'h00;
      end else begin
         cur <= next_cur;
         if (reg_rd && reg_addr == `VIMR_ADDR_REQ) begin
            rdata_q <= cur.req;
         end else if (reg_rd && reg_addr == `VIMR_ADDR_MASK) begin
            rdata_q <= cur.mask;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign reg_rdata = rdata_q;

   // ******************************
   // Checks
   // ******************************
   AST_MASK_BLOCKS: assert property (@(posedge ref_clk) disable iff (reset)
      irq_pending |-> (cur.mask[irq_index] && cur.req[irq_index]))
      else $error("pending request not enabled");
   AST_GLOBAL_GATE: assert property (@(posedge ref_clk) disable iff (reset)
      !cur.mask[`VIMR_GLOBAL_BIT] |-> !irq_pending)
      else $error("request seen with global enable off");
   AST_DISABLE_KEEPS: assert property (@(posedge ref_clk) disable iff (reset)
      (global_disable_instruction && !wr_mask) |=> (cur.mask[5:0] == $past(cur.mask[5:0])
      && !cur.mask[`VIMR_GLOBAL_BIT]))
      else $error("disable altered source enables");
   AST_ENABLE_INSTR: assert property (@(posedge ref_clk) disable iff (reset)
      (global_enable_instruction && !global_disable_instruction && !take)
      |=> cur.mask[`VIMR_GLOBAL_BIT])
      else $error("enable instruction did not set global bit");
   AST_ENTRY_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
      (take && !global_enable_instruction && !return_from_interrupt_instruction)
      |=> !cur.mask[`VIMR_GLOBAL_BIT] && in_service)
      else $error("service entry kept global enable");
   AST_RESET_ZERO: assert property (@(posedge ref_clk)
      $past(reset) |-> (cur.req == 8'h00 && cur.mask == 8'h00))
      else $error("registers not zero after reset");
   AST_HW_SET: assert property (@(posedge ref_clk) disable iff (reset)
      (src_pulse[2] && !wr_req) |=> cur.req[2])
      else $error("source pulse did not set flag");
   AST_WRITE_WINS: assert property (@(posedge ref_clk) disable iff (reset)
      wr_req |=> cur.req == $past(reg_wdata))
      else $error("write-back did not win");
   AST_PRIORITY: assert property (@(posedge ref_clk) disable iff (reset)
      irq_pending |-> ((eligible & ((6'h01 << irq_index) - 6'h01)) == 6'h00))
      else $error("higher priority request skipped");
   AST_ACK_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
      (take && !wr_req && !hw_set[win_idx]) |=> !cur.req[$past(win_idx)])
      else $error("acknowledge did not clear request");

   // ******************************
   // Further checks
   // ******************************
   AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");

   AST_READ_REQ: assert property (@(posedge ref_clk) disable iff (reset)
      (reg_rd && reg_addr == `VIMR_ADDR_REQ) |=> reg_rdata == $past(cur.req))
      else $error("request read mismatch");

   AST_READ_MASK: assert property (@(posedge ref_clk) disable iff (reset)
      (reg_rd && reg_addr == `VIMR_ADDR_MASK) |=> reg_rdata == $past(cur.mask))
      else $error("mask read mismatch");

   AST_RETURN_SETS: assert property (@(posedge ref_clk) disable iff (reset)
      (in_service && return_from_interrupt_instruction)
      |=> (cur.mask[`VIMR_GLOBAL_BIT] && !in_service))
      else $error("return did not restore global enable");

   AST_DISABLE_INSTR: assert property (@(posedge ref_clk) disable iff (reset)
      (global_disable_instruction && !(in_service && return_from_interrupt_instruction))
      |=> !cur.mask[`VIMR_GLOBAL_BIT])
      else $error("disable instruction did not clear global bit");

   AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
      (wr_mask && !global_enable_instruction && !global_disable_instruction
      && !take && !return_from_interrupt_instruction) |=> cur.mask == $past(reg_wdata))
      else $error("mask write lost");

   AST_PIN_SET: assert property (@(posedge ref_clk) disable iff (reset)
      (pin_rise[3] && !wr_req) |=> cur.req[3])
      else $error("pin edge did not set flag");

   AST_IDLE_NO_REQ: assert property (@(posedge ref_clk) disable iff (reset)
      (cur.req[5:0] == 6'h00) |-> !irq_pending)
      else $error("pending without any flag");

   AST_ONE_WINNER: assert property (@(posedge ref_clk) disable iff (reset)
      irq_pending |-> ($onehot(win_hot) && eligible[irq_index]))
      else $error("winner not a single eligible request");

   COV_VECTOR: cover property (@(posedge ref_clk) disable iff (reset) take);
   COV_RETURN: cover property (@(posedge ref_clk) disable iff (reset)
      in_service && return_from_interrupt_instruction);
   COV_SWI: cover property (@(posedge ref_clk) disable iff (reset) wr_req ##1 irq_pending);
   COV_LOST: cover property (@(posedge ref_clk) disable iff (reset) wr_req && |src_pulse);

endmodule
`default_nettype wire

// [testbench/vimr_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vimr_core_model (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       irq_pending,
   input  wire logic [3:0] lat,
   output logic            vector_ack
);
   logic [3:0] wait_cnt;
   // ***********************
   // Vector fetch
   // ***********************
   // Waits lat+1 cycles so the bench can see the winner before the ack
   always_ff @(posedge ref_clk) begin
      if (reset || !irq_pending || vector_ack) begin
         wait_cnt   <= 4'h0;
         vector_ack <= 1'b0;
      end else if (wait_cnt == lat) begin
         vector_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// [testbench/vimr_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vimr_cfg.svh"
module vimr_ctrl_tb_top;
   logic       ref_clk, reset, reg_wr, reg_rd, reg_hit, vector_ack;
   logic       irq_pending, in_service;
   logic [5:0] src_pulse, edge_pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, vector_addr;
   logic [2:0] irq_index, ins;
   logic [3:0] lat;
   int         error_cnt, samples_checked, n;

   vimr_ctrl i_vimr_ctrl (.ref_clk(ref_clk), .reset(reset), .src_pulse(src_pulse), .edge_pin(edge_pin),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .global_enable_instruction(ins[0]), .global_disable_instruction(ins[1]),
      .return_from_interrupt_instruction(ins[2]), .vector_ack(vector_ack), .irq_pending(irq_pending),
      .irq_index(irq_index), .vector_addr(vector_addr), .in_service(in_service));
   vimr_core_model i_vimr_core_model (.ref_clk(ref_clk), .reset(reset), .irq_pending(irq_pending),
      .lat(lat), .vector_ack(vector_ack));

   // ***********************
   // Bus tasks
   // ***********************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_ev(input logic [7:0] a, input logic [7:0] d, input logic [5:0] ev);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; src_pulse <= ev;
      @(posedge ref_clk);
      reg_wr <= 1'b0; src_pulse <= 6'h00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wr_ev(a, d, 6'h00);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      #1 chk({7'h00, reg_hit}, {7'h00, a == `VIMR_ADDR_REQ || a == `VIMR_ADDR_MASK});
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // Bit 0 enable, bit 1 disable, bit 2 return
   task automatic instr(input logic [2:0] k);
      @(posedge ref_clk);
      ins <= k;
      @(posedge ref_clk);
      ins <= 3'h0;
      #1;
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      finish_test();
   end

   // ***********************
   // Tests
   // ***********************
   initial begin
      {reset, reg_wr, reg_rd, reg_addr, reg_wdata, src_pulse, edge_pin, ins, lat} = {1'b1, 33'h0, 4'h6};
      error_cnt = 0; samples_checked = 0;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`VIMR_ADDR_REQ, 8'h00);
      rd(`VIMR_ADDR_MASK, 8'h00);
      rd(8'hfc, 8'h00);
      wr(`VIMR_ADDR_MASK, 8'h3f);
      wr_ev(8'h00, 8'h00, 6'h3f);
      #1 chk({7'h00, irq_pending}, 8'h00);
      rd(`VIMR_ADDR_REQ, 8'h3f);
      instr(3'h1);
      // Six flags pending, served strictly in index order
      for (int i = 0; i < 6; i++) begin
         for (n = 0; n < 20 && irq_pending !== 1'b1; n++) @(negedge ref_clk);
         chk({5'h00, irq_index}, i[7:0]);
         chk(vector_addr, 8'h02 + 8'(2 * i));
         for (n = 0; n < 20 && in_service !== 1'b1; n++) @(negedge ref_clk);
         rd(`VIMR_ADDR_MASK, 8'h3f);
         instr(3'h4);
         chk({7'h00, in_service}, 8'h00);
      end
      rd(`VIMR_ADDR_REQ, 8'h00);
      instr(3'h2);
      wr(`VIMR_ADDR_MASK, 8'h1f);
      wr(`VIMR_ADDR_REQ, 8'h20);
      instr(3'h1);
      chk({7'h00, irq_pending}, 8'h00);
      instr(3'h2);
      rd(`VIMR_ADDR_MASK, 8'h1f);
      wr(`VIMR_ADDR_MASK, 8'h3f);
      lat <= 4'h0;
      instr(3'h1);
      chk({7'h00, irq_pending}, 8'h01);
      chk(vector_addr, 8'h0c);
      for (n = 0; n < 20 && in_service !== 1'b1; n++) @(negedge ref_clk);
      rd(`VIMR_ADDR_REQ, 8'h00);
      instr(3'h4);
      instr(3'h2);
      edge_pin <= 6'h04;
      repeat (5) @(posedge ref_clk);
      rd(`VIMR_ADDR_REQ, 8'h04);
      wr_ev(`VIMR_ADDR_REQ, 8'h00, 6'h02);
      rd(`VIMR_ADDR_REQ, 8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
